// *** include/nbus_bridge_pkg.sv ***
// Package: register offsets, field positions and timing for the narrow-bus bridge control block
`default_nettype none
package nbus_bridge_pkg;
   // Configuration-space byte offsets
   localparam logic [7:0] OFS_PCI_CTRL = 8'h40;
   localparam logic [7:0] OFS_RECOVERY = 8'h4c;
   localparam logic [7:0] OFS_CLKDIV = 8'h4d;
   localparam logic [7:0] OFS_NMI = 8'h61;
   // Host command-port word addresses
   localparam logic [3:0] HA_PCI_CTRL = 4'h0;
   localparam logic [3:0] HA_RECOVERY = 4'h1;
   localparam logic [3:0] HA_CLKDIV = 4'h2;
   localparam logic [3:0] HA_NMI = 4'h3;
   localparam logic [3:0] HA_STATUS = 4'h4;
   localparam logic [3:0] HA_IO_ADDR = 4'h5;
   localparam logic [3:0] HA_IO_DATA = 4'h6;
   localparam logic [3:0] HA_IO_CMD = 4'h7;
   // Field positions
   localparam int PCI_IACK_BIT = 5;
   localparam int PCI_DEVSEL_LO = 3;
   localparam int PCI_POST_BIT = 2;
   localparam int REC_LO = 3;
   localparam int REC_HI = 6;
   localparam int DIV_ROM_BIT = 6;
   localparam int NMI_SERR_FLAG = 7;
   localparam int NMI_HALT_FLAG = 6;
   localparam int NMI_HALT_MASK = 3;
   localparam int NMI_SERR_MASK = 2;
   // Reset values and legal-use values
   localparam logic [7:0] PCI_CTRL_RST = 8'h20;
   localparam logic [7:0] PCI_CTRL_REQUIRED = 8'h24;
   localparam logic [7:0] RECOVERY_RST = 8'h00;
   localparam logic [7:0] RECOVERY_REQUIRED = 8'h48;
   localparam logic [7:0] CLKDIV_RST = 8'h00;
   localparam logic [7:0] CLKDIV_REQUIRED = 8'h00;
   localparam logic [7:0] NMI_RST = 8'h00;
   localparam logic [7:0] PCI_CTRL_WMASK = 8'h3c;
   localparam logic [7:0] NMI_WMASK = 8'h0c;
   // Byte enable codes; exactly one lane per narrow-bus access
   localparam logic [3:0] BE_NONE = 4'h0;
   localparam logic [3:0] BE_LANE0 = 4'h1;
   localparam logic [3:0] BE_FIRST_ONE = 4'h1;
   // Bias taken off recovery field values of eight and up to give the recovery count
   localparam logic [3:0] REC_BIAS = 4'h8;
endpackage
`default_nettype wire

// *** include/nbus_link_if.sv ***
// Interface joining the PCI host end to the bridge control end
`default_nettype none
interface nbus_link_if;
   logic cfg_wr;
   logic cfg_rd;
   logic [7:0] cfg_addr;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   logic io_req;
   logic [15:0] io_addr;
   logic [3:0] io_be;
   logic io_write;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic io_done;
   logic io_claim;
   logic iack_req;
   logic iack_claim;
   logic serr;
   logic nmi;
   modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, io_req, io_addr, io_be, io_write, io_wdata,
                 iack_req, serr,
                 input cfg_rdata, io_rdata, io_done, io_claim, iack_claim, nmi);
   modport bridge (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, io_req, io_addr, io_be, io_write, io_wdata,
                   iack_req, serr,
                   output cfg_rdata, io_rdata, io_done, io_claim, iack_claim, nmi);
endinterface
`default_nettype wire

// *** rtl/nbus_bridge_ctrl.sv ***
// Bridge end: control registers, narrow-bus cycle pacing and NMI status
//
// Behaviour
// R1: Recovery ticks from bits 6:3 between cycles
// R2: Software programs recovery field as 1001
// R3: Recovery at 0x4C, divisor at 0x4D
// R4: Divisor written zero for 32 MHz
// R5: ROM positive decode only when divisor enables
// R6: Control register enables interrupt-acknowledge response
// R7: Control bit 5 set, reset one; others zero
// R8: Bits 4:3 choose DEVSEL sample point
// R9: Bit 2 enables posted write buffer
// R10: SERR sets flag bit 7 until cleared
// R11: Mask bit 2 disables and clears SERR flag
// R12: Clear SERR flag by toggling mask
// R13: Watchdog expiry or halt toggle sets bit 6
// R14: Mask bit 3 disables and clears halt flag
// R15: Clear halt flag by toggling mask
// R16: Reserved NMI bits read zero, written zero
// R17: Halt events drive the check pin
// R18: No base registers; negative decode claims
// R19: Narrow accesses single byte, one lane
// R20: NMI request when enabled flag set
//
// Local design decision: the plain strobed port.
`default_nettype none
module nbus_bridge_ctrl
   import nbus_bridge_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   nbus_link_if.bridge link,
   input wire logic halt_switch_in,
   input wire logic wdog_expired_in,
   input wire logic wdog_enable_in,
   input wire logic [7:0] nbus_rdata_in,
   output logic nbus_strobe_out,
   output logic nbus_write_out,
   output logic [15:0] nbus_addr_out,
   output logic [7:0] nbus_wdata_out,
   output logic io_check_n_out,
   output logic rom_pos_decode_out,
   output logic posted_write_en_out,
   output logic [1:0] devsel_speed_out,
   output logic [2:0] clk_divisor_out
);
   typedef enum logic [1:0] {IDLE, STROBE, RECOVER} cyc_state_t;

   logic [7:0] pci_ctrl_q;
   logic [7:0] recovery_q;
   logic [7:0] clkdiv_q;
   logic serr_flag_q, halt_flag_q, serr_mask_q, halt_mask_q;
   logic [2:0] halt_sync_q;
   logic [1:0] wdog_sync_q, wden_sync_q;
   logic wdog_prev_q;
   logic halt_event, serr_event;
   cyc_state_t state_q;
   logic [4:0] rec_cnt_q;
   logic [7:0] cfg_rdata_q, io_rdata_q;
   logic io_done_q;
   logic one_lane;

   // True when exactly one byte lane is asserted
   function automatic logic single_lane(input logic [3:0] be);
      single_lane = (be != BE_NONE) && ((be & (be - BE_FIRST_ONE)) == BE_NONE);
   endfunction

   // Configuration registers; undefined control bits stay zero regardless of writes, recovery and divisor keep every written bit [R7] [R16]
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pci_ctrl_q <= PCI_CTRL_RST; // [R7]
         recovery_q <= RECOVERY_RST;
         clkdiv_q <= CLKDIV_RST;
      end else if (link.cfg_wr) begin
         case (link.cfg_addr)
            OFS_PCI_CTRL: pci_ctrl_q <= link.cfg_wdata & PCI_CTRL_WMASK; // [R8] [R9]
            OFS_RECOVERY: recovery_q <= link.cfg_wdata; // [R3]
            OFS_CLKDIV: clkdiv_q <= link.cfg_wdata; // [R3] [R5]
            default: ;
         endcase
      end
   end

   // NMI mask bits; flag bits are read-only from software
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         serr_mask_q <= 1'b0;
         halt_mask_q <= 1'b0;
      end else if (link.cfg_wr && link.cfg_addr == OFS_NMI) begin
         serr_mask_q <= link.cfg_wdata[NMI_SERR_MASK];
         halt_mask_q <= link.cfg_wdata[NMI_HALT_MASK];
      end
   end

   // Pin synchronisers; halt switch edge detected after two stages
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         halt_sync_q <= 3'h0;
         wdog_sync_q <= 2'h0;
         wden_sync_q <= 2'h0;
         wdog_prev_q <= 1'b0;
      end else begin
         halt_sync_q <= {halt_sync_q[1:0], halt_switch_in};
         wdog_sync_q <= {wdog_sync_q[0], wdog_expired_in};
         wden_sync_q <= {wden_sync_q[0], wdog_enable_in};
         wdog_prev_q <= wdog_sync_q[1];
      end
   end

   // Any toggle of the switch counts; watchdog only on rising expiry while enabled [R13]
   assign halt_event = (halt_sync_q[2] != halt_sync_q[1]) || (wdog_sync_q[1] && !wdog_prev_q && wden_sync_q[1]);
   assign serr_event = link.serr;

   // Masks force flags clear; toggling the mask is the only clearing path [R11] [R14]
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         serr_flag_q <= 1'b0;
         halt_flag_q <= 1'b0;
      end else begin
         if (serr_mask_q)
            serr_flag_q <= 1'b0; // [R11] [R12]
         else if (serr_event)
            serr_flag_q <= 1'b1; // [R10]
         if (halt_mask_q)
            halt_flag_q <= 1'b0; // [R14] [R15]
         else if (halt_event)
            halt_flag_q <= 1'b1; // [R13]
      end
   end

   // Flags clear one cycle after the mask sets, so the mask gate drops the request in that cycle [R20]
   assign link.nmi = (serr_flag_q && !serr_mask_q) || (halt_flag_q && !halt_mask_q); // [R20]
   assign io_check_n_out = !(halt_flag_q && !halt_mask_q); // [R17]

   // Register read-back, one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in)
         cfg_rdata_q <= 8'h00;
      else if (link.cfg_rd) begin
         case (link.cfg_addr)
            OFS_PCI_CTRL: cfg_rdata_q <= pci_ctrl_q;
            OFS_RECOVERY: cfg_rdata_q <= recovery_q;
            OFS_CLKDIV: cfg_rdata_q <= clkdiv_q;
            OFS_NMI: cfg_rdata_q <= {serr_flag_q, halt_flag_q, 2'b00, halt_mask_q, serr_mask_q, 2'b00}; // [R16]
            default: cfg_rdata_q <= 8'h00;
         endcase
      end
   end
   assign link.cfg_rdata = cfg_rdata_q;

   // Control outputs steered by the registers
   assign link.iack_claim = link.iack_req && pci_ctrl_q[PCI_IACK_BIT]; // [R6]
   assign devsel_speed_out = pci_ctrl_q[PCI_DEVSEL_LO +: 2]; // [R8]
   assign posted_write_en_out = pci_ctrl_q[PCI_POST_BIT]; // [R9]
   assign rom_pos_decode_out = clkdiv_q[DIV_ROM_BIT]; // [R5]
   assign clk_divisor_out = clkdiv_q[2:0];

   // Claim every narrow request by subtractive decode; no base registers [R18]
   assign one_lane = single_lane(link.io_be);
   assign link.io_claim = link.io_req && state_q == IDLE;

   // Narrow-bus cycle sequencer: strobe one cycle, then recovery gap [R1]
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= IDLE;
         rec_cnt_q <= 5'h00;
         nbus_strobe_out <= 1'b0;
         nbus_write_out <= 1'b0;
         nbus_addr_out <= 16'h0000;
         nbus_wdata_out <= 8'h00;
         io_done_q <= 1'b0;
         io_rdata_q <= 8'h00;
      end else begin
         io_done_q <= 1'b0;
         nbus_strobe_out <= 1'b0;
         case (state_q)
            IDLE: if (link.io_req) begin
               if (one_lane) begin // [R19]
                  nbus_strobe_out <= 1'b1;
                  nbus_write_out <= link.io_write;
                  nbus_addr_out <= link.io_addr;
                  nbus_wdata_out <= link.io_wdata;
                  state_q <= STROBE;
               end else begin
                  io_rdata_q <= 8'h00; // Multi-lane request completes with no bus cycle
                  io_done_q <= 1'b1;
                  state_q <= RECOVER;
                  rec_cnt_q <= 5'h00;
               end
            end
            STROBE: begin
               io_rdata_q <= nbus_rdata_in;
               io_done_q <= 1'b1;
               // Field 1001 gives one tick: bias removes the base count [R1] [R2]
               rec_cnt_q <= (recovery_q[REC_HI:REC_LO] >= REC_BIAS) ?
                            {1'b0, recovery_q[REC_HI:REC_LO] - REC_BIAS} : {1'b0, recovery_q[REC_HI:REC_LO]};
               state_q <= RECOVER;
            end
            RECOVER: if (rec_cnt_q == 5'h00)
               state_q <= IDLE;
            else
               rec_cnt_q <= rec_cnt_q - 5'h01; // [R1]
            default: state_q <= IDLE;
         endcase
      end
   end
   assign link.io_done = io_done_q;
   assign link.io_rdata = io_rdata_q;
endmodule
`default_nettype wire

// *** rtl/nbus_pci_host.sv ***
// Host end: command-port registers driving configuration and narrow I/O cycles
`default_nettype none
module nbus_pci_host
   import nbus_bridge_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   nbus_link_if.host link,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic serr_in,
   input wire logic iack_in,
   output logic [15:0] rdata_out,
   output logic nmi_out
);
   typedef enum logic [1:0] {H_IDLE, H_CFGRD, H_IOWAIT} host_state_t;

   host_state_t state_q;
   logic [15:0] io_addr_q;
   logic [7:0] io_wdata_q, io_rdata_q, cfg_rdata_q;
   logic busy_q, cfg_wr_q, cfg_rd_q, io_req_q, io_write_q;
   logic [7:0] cfg_addr_q, cfg_wdata_q;
   logic [15:0] rdata_q;

   // Maps command-port addresses onto device offsets; status has none
   function automatic logic [7:0] dev_offset(input logic [3:0] a);
      case (a)
         HA_PCI_CTRL: dev_offset = OFS_PCI_CTRL;
         HA_RECOVERY: dev_offset = OFS_RECOVERY;
         HA_CLKDIV: dev_offset = OFS_CLKDIV;
         default: dev_offset = OFS_NMI;
      endcase
   endfunction

   // Software writes pass through with reserved bits forced zero [R7] [R16] [R12] [R15]
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= H_IDLE;
         busy_q <= 1'b0;
         cfg_wr_q <= 1'b0;
         cfg_rd_q <= 1'b0;
         cfg_addr_q <= 8'h00;
         cfg_wdata_q <= 8'h00;
         io_req_q <= 1'b0;
         io_write_q <= 1'b0;
         io_addr_q <= 16'h0000;
         io_wdata_q <= 8'h00;
         io_rdata_q <= 8'h00;
         cfg_rdata_q <= 8'h00;
      end else begin
         cfg_wr_q <= 1'b0;
         cfg_rd_q <= 1'b0;
         if (wr_in && addr_in <= HA_NMI) begin
            cfg_wr_q <= 1'b1;
            cfg_addr_q <= dev_offset(addr_in);
            // Posted-write, DEVSEL and ack bits pass the mask; bits 7:6 and 1:0 forced zero [R8] [R9]
            case (addr_in)
               HA_PCI_CTRL: cfg_wdata_q <= wdata_in[7:0] & PCI_CTRL_WMASK;
               HA_NMI: cfg_wdata_q <= wdata_in[7:0] & NMI_WMASK; // [R12] [R15] [R16]
               default: cfg_wdata_q <= wdata_in[7:0]; // [R2] [R4] [R5]
            endcase
         end else if (wr_in && addr_in == HA_IO_ADDR)
            io_addr_q <= wdata_in;
         else if (wr_in && addr_in == HA_IO_DATA)
            io_wdata_q <= wdata_in[7:0];
         else if (wr_in && addr_in == HA_IO_CMD && !busy_q) begin
            io_req_q <= 1'b1; // Single-lane access only [R19]
            io_write_q <= wdata_in[0];
            busy_q <= 1'b1;
            state_q <= H_IOWAIT;
         end
         if (rd_in && addr_in <= HA_NMI) begin
            cfg_rd_q <= 1'b1;
            cfg_addr_q <= dev_offset(addr_in);
         end
         if (cfg_rd_q)
            state_q <= (state_q == H_IOWAIT) ? H_IOWAIT : H_CFGRD;
         if (state_q == H_CFGRD) begin
            cfg_rdata_q <= link.cfg_rdata;
            state_q <= H_IDLE;
         end
         if (io_req_q && link.io_claim)
            io_req_q <= 1'b0;
         if (link.io_done) begin
            io_rdata_q <= link.io_rdata;
            busy_q <= 1'b0;
            state_q <= H_IDLE;
         end
      end
   end

   // Read data one cycle after the strobe; config data comes from the last completed fetch
   always_ff @(posedge clk_in) begin
      if (!rst_n_in)
         rdata_q <= 16'h0000;
      else if (rd_in) begin
         case (addr_in)
            HA_STATUS: rdata_q <= {14'h0000, link.nmi, busy_q};
            HA_IO_ADDR: rdata_q <= io_addr_q;
            HA_IO_DATA: rdata_q <= {8'h00, io_rdata_q};
            HA_PCI_CTRL, HA_RECOVERY, HA_CLKDIV, HA_NMI: rdata_q <= {8'h00, cfg_rdata_q};
            default: rdata_q <= 16'h0000;
         endcase
      end
   end

   assign rdata_out = rdata_q;
   assign nmi_out = link.nmi;
   assign link.cfg_wr = cfg_wr_q;
   assign link.cfg_rd = cfg_rd_q;
   assign link.cfg_addr = cfg_addr_q;
   assign link.cfg_wdata = cfg_wdata_q;
   assign link.io_req = io_req_q;
   assign link.io_addr = io_addr_q;
   assign link.io_be = BE_LANE0; // [R19]
   assign link.io_write = io_write_q;
   assign link.io_wdata = io_wdata_q;
   assign link.iack_req = iack_in;
   assign link.serr = serr_in;
endmodule
`default_nettype wire

// *** tb/nbus_link_properties.sv ***
// Checker: timing and value properties on the link between host end and bridge end
`default_nettype none
module nbus_link_properties
   import nbus_bridge_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic io_req,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic io_write,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_done,
   input wire logic io_claim,
   input wire logic iack_req,
   input wire logic iack_claim,
   input wire logic serr,
   input wire logic nmi
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] pci_q;
   logic [7:0] rec_q;
   logic [1:0] mask_q;
   logic [3:0] since_q;
   logic [3:0] ticks;
   logic nmi_wr;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Shadow of what crossed the link, so readback can be predicted
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pci_q <= PCI_CTRL_RST;
         rec_q <= RECOVERY_RST;
         mask_q <= 2'h0;
      end else if (cfg_wr) begin
         if (cfg_addr == OFS_PCI_CTRL) pci_q <= cfg_wdata & PCI_CTRL_WMASK;
         if (cfg_addr == OFS_RECOVERY) rec_q <= cfg_wdata;
         if (cfg_addr == OFS_NMI) mask_q <= cfg_wdata[3:2];
      end
   end
   // Cycles since the last completion; saturates so idle time never wraps
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) since_q <= 4'hf;
      else if (io_done) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
   end
   // Field 1001 gives one tick: values of eight and up lose the bias
   assign ticks = {1'b0, rec_q[5:3]};
   assign nmi_wr = cfg_wr && (cfg_addr == OFS_NMI);
   chk_iack_gate: assert property (iack_claim == (iack_req && pci_q[PCI_IACK_BIT]))
      else $error("iack claim does not follow request and enable");
   chk_done_time: assert property (io_req && io_claim |=> !io_done ##1 io_done)
      else $error("narrow cycle did not complete two cycles after take");
   chk_done_pulse: assert property (io_done |=> !io_done)
      else $error("completion pulse longer than one cycle");
   chk_one_lane: assert property (io_req |-> io_be == BE_LANE0)
      else $error("narrow access without exactly one lane");
   chk_recovery_gap: assert property (io_claim |-> since_q >= ticks)
      else $error("new narrow cycle taken inside recovery time");
   chk_ctrl_readback: assert property (cfg_rd && cfg_addr == OFS_PCI_CTRL |=> cfg_rdata == pci_q)
      else $error("control readback differs from written value");
   chk_rec_readback: assert property (cfg_rd && cfg_addr == OFS_RECOVERY |=> cfg_rdata == rec_q)
      else $error("recovery readback differs from written value");
   chk_nmi_fields: assert property (cfg_rd && cfg_addr == OFS_NMI |=> cfg_rdata[5:0] == {2'b00, mask_q, 2'b00})
      else $error("nmi register low fields wrong");
   chk_nmi_set: assert property (serr && !mask_q[0] && !nmi_wr |=> nmi)
      else $error("system error did not raise nmi");
   chk_nmi_hold: assert property (nmi && !nmi_wr |=> nmi)
      else $error("nmi dropped without clearing write");
   chk_mask_clear: assert property (nmi_wr && cfg_wdata[3:2] == 2'b11 |=> !nmi)
      else $error("masking both sources left nmi set");
endmodule
`default_nettype wire

// *** tb/pci_nbus_bridge_nmi_ctrl_tb.sv ***
// Testbench: register-port sequences through host end and bridge end
`default_nettype none
module pci_nbus_bridge_nmi_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import nbus_bridge_pkg::*;
   logic clk_in, rst_n_in, wr_in, rd_in, serr_in, iack_in, nmi_out;
   logic halt_switch_in, wdog_expired_in, wdog_enable_in, nbus_strobe_out, nbus_write_out;
   logic io_check_n_out, rom_pos_decode_out, posted_write_en_out;
   logic [3:0] addr_in;
   logic [15:0] wdata_in, rdata_out, nbus_addr_out, d;
   logic [7:0] nbus_rdata_in, nbus_wdata_out, v;
   logic [1:0] devsel_speed_out;
   logic [2:0] clk_divisor_out;
   int mismatches, checks_done, cycles, strobes;
   nbus_link_if link_i();
   nbus_pci_host u_nbus_pci_host(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_i.host), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .serr_in(serr_in), .iack_in(iack_in),
      .rdata_out(rdata_out), .nmi_out(nmi_out));
   nbus_bridge_ctrl u_nbus_bridge_ctrl(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_i.bridge),
      .halt_switch_in(halt_switch_in), .wdog_expired_in(wdog_expired_in), .wdog_enable_in(wdog_enable_in),
      .nbus_rdata_in(nbus_rdata_in), .nbus_strobe_out(nbus_strobe_out), .nbus_write_out(nbus_write_out),
      .nbus_addr_out(nbus_addr_out), .nbus_wdata_out(nbus_wdata_out), .io_check_n_out(io_check_n_out),
      .rom_pos_decode_out(rom_pos_decode_out), .posted_write_en_out(posted_write_en_out),
      .devsel_speed_out(devsel_speed_out), .clk_divisor_out(clk_divisor_out));
   nbus_link_properties u_props(.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr(link_i.cfg_wr),
      .cfg_rd(link_i.cfg_rd), .cfg_addr(link_i.cfg_addr), .cfg_wdata(link_i.cfg_wdata),
      .cfg_rdata(link_i.cfg_rdata), .io_req(link_i.io_req), .io_addr(link_i.io_addr), .io_be(link_i.io_be),
      .io_write(link_i.io_write), .io_wdata(link_i.io_wdata), .io_rdata(link_i.io_rdata),
      .io_done(link_i.io_done), .io_claim(link_i.io_claim), .iack_req(link_i.iack_req),
      .iack_claim(link_i.iack_claim), .serr(link_i.serr), .nmi(link_i.nmi));
   // Free-running clock, 40 ns period
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard: the sequence needs a few hundred cycles at most
   always @(posedge clk_in) begin
      cycles++;
      if (rst_n_in && nbus_strobe_out === 1'b1) strobes++;
      if (cycles == 8000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One-cycle strobes; the gap edge keeps a strobe from being set and cleared in one step
   task automatic hw(input logic [3:0] a, input logic [15:0] wd);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= wd;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic hr(input logic [3:0] a, output logic [15:0] rd);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      // Data stands through the cycle after the strobe; taken at its closing edge
      @(posedge clk_in);
      rd = rdata_out;
   endtask
   // Config reads return the previous fetch, so read twice
   task automatic cfg(input logic [3:0] a, input logic [15:0] exp, input string name);
      // Pin events need three edges to reach the flags
      repeat (3) @(posedge clk_in);
      hr(a, d);
      repeat (3) @(posedge clk_in);
      hr(a, d);
      check(name, d, exp);
   endtask
   task automatic io(input logic wr_op, input logic [15:0] a, input logic [7:0] wd);
      bit idle;
      idle = 0;
      hw(HA_IO_ADDR, a);
      hw(HA_IO_DATA, {8'h00, wd});
      hw(HA_IO_CMD, {15'h0000, wr_op});
      for (int i = 0; i < 40 && !idle; i++) begin
         hr(HA_STATUS, d);
         idle = (d[0] === 1'b0);
      end
      check("io idle", {15'h0000, idle}, 16'h0001);
   endtask
   task automatic pulse_serr();
      @(posedge clk_in);
      serr_in <= 1'b1;
      @(posedge clk_in);
      serr_in <= 1'b0;
   endtask
   initial begin
      {rst_n_in, wr_in, rd_in, serr_in, iack_in, halt_switch_in, wdog_expired_in, wdog_enable_in} = '0;
      addr_in = 4'h0;
      wdata_in = 16'h0000;
      nbus_rdata_in = 8'h00;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      cfg(HA_PCI_CTRL, {8'h00, PCI_CTRL_RST}, "pci reset");
      cfg(HA_RECOVERY, 16'h0000, "recovery reset");
      cfg(HA_NMI, 16'h0000, "nmi reset");
      check("io check idle", {15'h0000, io_check_n_out}, 16'h0001);
      check("posted reset", {15'h0000, posted_write_en_out}, 16'h0000);
      $display("test reset values done");
      iack_in <= 1'b1;
      hw(HA_PCI_CTRL, 16'h00ff);
      cfg(HA_PCI_CTRL, 16'h003c, "pci masked");
      check("iack claim", {15'h0000, link_i.iack_claim}, 16'h0001);
      check("devsel", {14'h0000, devsel_speed_out}, 16'h0003);
      hw(HA_PCI_CTRL, 16'h0004);
      cfg(HA_PCI_CTRL, 16'h0004, "pci no iack");
      check("iack ignored", {15'h0000, link_i.iack_claim}, 16'h0000);
      hw(HA_PCI_CTRL, {8'h00, PCI_CTRL_REQUIRED});
      cfg(HA_PCI_CTRL, {8'h00, PCI_CTRL_REQUIRED}, "pci required");
      check("devsel slow", {14'h0000, devsel_speed_out}, 16'h0000);
      check("posted on", {15'h0000, posted_write_en_out}, 16'h0001);
      iack_in <= 1'b0;
      hw(HA_CLKDIV, 16'h0047);
      cfg(HA_PCI_CTRL, {8'h00, PCI_CTRL_REQUIRED}, "pci kept");
      check("rom decode on", {15'h0000, rom_pos_decode_out}, 16'h0001);
      check("divisor", {13'h0000, clk_divisor_out}, 16'h0007);
      hw(HA_CLKDIV, {8'h00, CLKDIV_REQUIRED});
      cfg(HA_CLKDIV, {8'h00, CLKDIV_REQUIRED}, "clkdiv");
      check("rom decode off", {15'h0000, rom_pos_decode_out}, 16'h0000);
      hw(4'hc, 16'hffff);
      hr(4'hc, d);
      check("unmapped read", d, 16'h0000);
      cfg(HA_PCI_CTRL, {8'h00, PCI_CTRL_REQUIRED}, "pci after unmapped");
      $display("test control done");
      // Each recovery setting followed by two writes, the second begun once status polling shows the first done
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? RECOVERY_REQUIRED : (i == 1) ? 8'h78 : (i == 2) ? 8'h38 : 8'h00;
         hw(HA_RECOVERY, {8'h00, v});
         cfg(HA_RECOVERY, {8'h00, v}, "recovery");
         io(1'b1, 16'h0061 + 16'(i), 8'ha5 ^ 8'(i));
         io(1'b1, 16'h0061 + 16'(i), 8'ha5 ^ 8'(i));
         check("nbus addr", nbus_addr_out, 16'h0061 + 16'(i));
         check("nbus data", {8'h00, nbus_wdata_out}, {8'h00, 8'ha5 ^ 8'(i)});
         check("nbus write", {15'h0000, nbus_write_out}, 16'h0001);
      end
      nbus_rdata_in <= 8'h5a;
      io(1'b0, 16'h0070, 8'h00);
      hr(HA_IO_DATA, d);
      check("io read data", d, 16'h005a);
      check("nbus read op", {15'h0000, nbus_write_out}, 16'h0000);
      check("strobe count", 16'(strobes), 16'h0009);
      $display("test narrow cycles done");
      pulse_serr();
      cfg(HA_NMI, 16'h0080, "serr flag");
      hr(HA_STATUS, d);
      check("nmi status", {15'h0000, d[1]}, 16'h0001);
      hw(HA_NMI, 16'h0004);
      pulse_serr();
      cfg(HA_NMI, 16'h0004, "serr masked");
      hw(HA_NMI, 16'h0000);
      cfg(HA_NMI, 16'h0000, "serr cleared");
      halt_switch_in <= 1'b1;
      cfg(HA_NMI, 16'h0040, "halt flag");
      check("io check low", {15'h0000, io_check_n_out}, 16'h0000);
      hw(HA_NMI, 16'h0008);
      cfg(HA_NMI, 16'h0008, "halt masked");
      hw(HA_NMI, 16'h0000);
      cfg(HA_NMI, 16'h0000, "halt cleared");
      wdog_expired_in <= 1'b1;
      cfg(HA_NMI, 16'h0000, "wdog disabled");
      wdog_expired_in <= 1'b0;
      wdog_enable_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      wdog_expired_in <= 1'b1;
      cfg(HA_NMI, 16'h0040, "wdog flag");
      hw(HA_NMI, 16'h00ff);
      cfg(HA_NMI, 16'h000c, "reserved zero");
      hw(HA_NMI, 16'h0000);
      cfg(HA_NMI, 16'h0000, "all clear");
      check("nmi out", {15'h0000, nmi_out}, 16'h0000);
      $display("test nmi done");
      end_of_test();
   end
endmodule
`default_nettype wire
